// *** core/serial_cfg_slave.v ***
// two-wire serial slave: device address, sub-address, data bytes
// assumes scl and sda arrive synchronous to clk_i and change slowly
// against it; sda is open drain, low while sda_oe_o is high
`timescale 1ns/1ns
`default_nettype none
`include "sync_clock_map.vh"

module serial_cfg_slave (
	input wire clk_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	input wire addr_lsb_i,
	output wire [7:0] rd_addr_o,
	input wire [7:0] rd_data_i,
	output reg [7:0] wr_addr_o,
	output reg [7:0] wr_data_o,
	output reg wr_stb_o
);

localparam ST_IDLE = 7'h01;
localparam ST_ADDR = 7'h02;
localparam ST_ACK = 7'h04;
localparam ST_SUB = 7'h08;
localparam ST_WR = 7'h10;
localparam ST_TX = 7'h20;
localparam ST_RACK = 7'h40;

reg [6:0] state_ff;
reg scl_q_ff;
reg sda_q_ff;
reg [7:0] shift_ff;
reg [3:0] cnt_ff;
reg rw_ff;
reg have_sub_ff;
reg [7:0] ptr_ff;
reg low_ff;

wire scl_rise = scl_i & ~scl_q_ff;
wire scl_fall = ~scl_i & scl_q_ff;
wire start_cond = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
wire stop_cond = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

assign sda_o = 1'b0;
assign sda_oe_o = low_ff;
assign rd_addr_o = ptr_ff;

////////////////////////////////////////////////////////////////////////
always @(posedge clk_i) begin
	scl_q_ff <= scl_i;
	sda_q_ff <= sda_i;
	wr_stb_o <= 1'b0;
	if (rst_i) begin
		state_ff <= ST_IDLE;
		shift_ff <= 8'h00;
		cnt_ff <= 4'h0;
		rw_ff <= 1'b0;
		have_sub_ff <= 1'b0;
		ptr_ff <= 8'h00;
		low_ff <= 1'b0;
		wr_addr_o <= 8'h00;
		wr_data_o <= 8'h00;
		scl_q_ff <= 1'b1;
		sda_q_ff <= 1'b1;
	end else if (start_cond) begin
		state_ff <= ST_ADDR;
		cnt_ff <= 4'h0;
		have_sub_ff <= 1'b0;
		low_ff <= 1'b0;
	end else if (stop_cond) begin
		state_ff <= ST_IDLE;
		low_ff <= 1'b0;
	end else begin
		case (state_ff)
		ST_ADDR, ST_SUB, ST_WR: begin
			// host clock captures each written bit on its rising edge
			if (scl_rise) begin
				shift_ff <= {shift_ff[6:0], sda_i}; // RULE10
				cnt_ff <= cnt_ff + 4'h1;
			end else if (scl_fall && cnt_ff == 4'h8) begin
				cnt_ff <= 4'h0;
				state_ff <= ST_ACK;
				low_ff <= 1'b1;
				if (state_ff == ST_ADDR) begin
					// two devices share a bus through the strapped lsb
					if (shift_ff[7:1] != {`SER_ADDR_BASE, addr_lsb_i}) begin // RULE11
						state_ff <= ST_IDLE;
						low_ff <= 1'b0;
					end
					rw_ff <= shift_ff[0];
				end else if (state_ff == ST_SUB) begin
					ptr_ff <= shift_ff;
					have_sub_ff <= 1'b1;
				end else begin
					wr_addr_o <= ptr_ff;
					wr_data_o <= shift_ff;
					wr_stb_o <= 1'b1;
					ptr_ff <= ptr_ff + 8'h01;
				end
			end
		end
		ST_ACK: begin
			if (scl_fall) begin
				cnt_ff <= 4'h0;
				if (rw_ff) begin
					state_ff <= ST_TX;
					shift_ff <= rd_data_i;
					low_ff <= ~rd_data_i[7];
					ptr_ff <= ptr_ff + 8'h01;
				end else begin
					state_ff <= have_sub_ff ? ST_WR : ST_SUB;
					low_ff <= 1'b0;
				end
			end
		end
		ST_TX: begin
			// contents leave toward the host on falling host clock edges
			if (scl_rise) begin
				cnt_ff <= cnt_ff + 4'h1;
			end else if (scl_fall) begin
				if (cnt_ff == 4'h8) begin
					state_ff <= ST_RACK;
					low_ff <= 1'b0;
				end else begin
					shift_ff <= {shift_ff[6:0], 1'b0};
					low_ff <= ~shift_ff[6]; // RULE10
				end
			end
		end
		ST_RACK: begin
			// host nack ends the read burst
			if (scl_rise) begin
				state_ff <= sda_i ? ST_IDLE : ST_ACK;
			end
		end
		default: begin
			low_ff <= 1'b0;
		end
		endcase
	end
end

endmodule // serial_cfg_slave
`default_nettype wire

// *** core/sync_clock_input_control.v ***
// sync input selection, clamp and holdover gating, sampling clock
// generation with source select, phase taps and inversion
// assumes every pin input is synchronous to clk_i and that the
// sampling clock rate is well below half of clk_i
//
// Notes on behaviour
// RULE1: line sync input takes logic or composite sync
// RULE2: gate register bit lets pin drive clamp
// RULE3: source asserts gate only in black interval
// RULE4: enabled holdover pin freezes generator, ignores edges
// RULE5: holdover may come from processed frame sync
// RULE6: clock source bit selects external sampling clock
// RULE7: phase adjust also works on external clock
// RULE8: invert pin shifts sampling clock 180 degrees
// RULE9: host toggles invert on alternate frames
// RULE10: host clock shifts serial data in, out
// RULE11: strap sets serial address least significant bit
// RULE12: frame sync output is delayed selected input
// RULE13: disabled pins ignored, internal timing used instead
`timescale 1ns/1ns
`default_nettype none
`include "sync_clock_map.vh"

module sync_clock_input_control #(
	// arbitrary revision value
	parameter [7:0] REVISION = 8'h11
) (
	input wire clk_i,
	input wire rst_i,
	input wire line_sync_in_a_i,
	input wire frame_sync_in_a_i,
	input wire line_sync_in_b_i,
	input wire frame_sync_in_b_i,
	input wire green_embedded_sync_in_a_i,
	input wire green_embedded_sync_in_b_i,
	input wire black_gate_in_i,
	input wire holdover_in_i,
	input wire external_sample_clock_in_i,
	input wire sample_clock_invert_in_i,
	input wire bus_address_strap_i,
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_o,
	output reg sample_clock_o,
	output reg sample_strobe_o,
	output reg clamp_o,
	output reg holdover_o,
	output reg frame_sync_out_o
);

function rising;
	input cur;
	input prev;
	begin
		rising = cur & ~prev;
	end
endfunction

////////////////////////////////////////////////////////////////////////
// strap capture and serial access

reg strap_ff;
reg strap_done_ff;
wire [7:0] rd_addr;
reg [7:0] rd_data;
wire [7:0] wr_addr;
wire [7:0] wr_data;
wire wr_stb;

// strap is caught once, on the first clock after reset release
always @(posedge clk_i) begin
	if (rst_i) begin
		strap_done_ff <= 1'b0;
		strap_ff <= 1'b0;
	end else if (!strap_done_ff) begin
		strap_done_ff <= 1'b1;
		strap_ff <= bus_address_strap_i; // RULE11
	end
end

serial_cfg_slave u_serial (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.addr_lsb_i(strap_ff),
	.rd_addr_o(rd_addr),
	.rd_data_i(rd_data),
	.wr_addr_o(wr_addr),
	.wr_data_o(wr_data),
	.wr_stb_o(wr_stb)
);

////////////////////////////////////////////////////////////////////////
// configuration registers

reg [7:0] input_ctrl_ff;
reg [7:0] sync_mode_ff;
reg [7:0] clamp_start_ff;
reg [7:0] clamp_len_ff;
reg [4:0] phase_ff;
reg [7:0] half_period_ff;
reg [3:0] frame_delay_ff;
reg [7:0] clock_src_ff;

always @(posedge clk_i) begin
	if (rst_i) begin
		input_ctrl_ff <= `RST_INPUT_CTRL;
		sync_mode_ff <= `RST_SYNC_MODE;
		clamp_start_ff <= `RST_CLAMP_START;
		clamp_len_ff <= `RST_CLAMP_LEN;
		phase_ff <= `RST_PHASE;
		half_period_ff <= `RST_HALF_PERIOD;
		frame_delay_ff <= `RST_FRAME_DELAY;
		clock_src_ff <= `RST_CLOCK_SRC;
	end else if (wr_stb) begin
		case (wr_addr)
		`REG_INPUT_CTRL: input_ctrl_ff <= wr_data;
		`REG_SYNC_MODE: sync_mode_ff <= wr_data;
		`REG_CLAMP_START: clamp_start_ff <= wr_data;
		`REG_CLAMP_LEN: clamp_len_ff <= wr_data;
		`REG_PHASE: phase_ff <= wr_data[4:0];
		`REG_HALF_PERIOD: half_period_ff <= wr_data;
		`REG_FRAME_DELAY: frame_delay_ff <= wr_data[3:0];
		`REG_CLOCK_SRC: clock_src_ff <= wr_data;
		default: begin
		end
		endcase
	end
end

wire sel_b = input_ctrl_ff[`INPUT_CTRL_SEL_B];
wire use_green = input_ctrl_ff[`INPUT_CTRL_GREEN];
wire ext_gate_en = sync_mode_ff[`SYNC_MODE_EXT_GATE];
wire ext_hold_en = sync_mode_ff[`SYNC_MODE_EXT_HOLD];
wire ext_clk_en = clock_src_ff[`CLOCK_SRC_EXT];

always @* begin
	case (rd_addr)
	`REG_REVISION: rd_data = REVISION;
	`REG_INPUT_CTRL: rd_data = input_ctrl_ff;
	`REG_SYNC_MODE: rd_data = sync_mode_ff;
	`REG_CLAMP_START: rd_data = clamp_start_ff;
	`REG_CLAMP_LEN: rd_data = clamp_len_ff;
	`REG_PHASE: rd_data = {3'h0, phase_ff};
	`REG_HALF_PERIOD: rd_data = half_period_ff;
	`REG_FRAME_DELAY: rd_data = {4'h0, frame_delay_ff};
	`REG_CLOCK_SRC: rd_data = clock_src_ff;
	`REG_STATUS: rd_data = {4'h0, frame_sync_out_o, clamp_o,
		holdover_o, ext_clk_en};
	default: rd_data = 8'h00;
	endcase
end

////////////////////////////////////////////////////////////////////////
// sync input selection

// a composite logic-level sync is simply taken on the line sync pin
wire line_pin = sel_b ? line_sync_in_b_i : line_sync_in_a_i; // RULE1
wire green_pin = sel_b ? green_embedded_sync_in_b_i :
	green_embedded_sync_in_a_i;
wire line_sync = use_green ? green_pin : line_pin;
wire frame_sync = sel_b ? frame_sync_in_b_i : frame_sync_in_a_i;

reg line_q_ff;
reg [`FRAME_DELAY_TAPS-1:0] frame_sr_ff;

always @(posedge clk_i) begin
	if (rst_i) begin
		line_q_ff <= 1'b0;
		frame_sr_ff <= {`FRAME_DELAY_TAPS{1'b0}};
		frame_sync_out_o <= 1'b0;
	end else begin
		line_q_ff <= line_sync;
		frame_sr_ff <= {frame_sr_ff[`FRAME_DELAY_TAPS-2:0], frame_sync};
		frame_sync_out_o <= frame_sr_ff[frame_delay_ff]; // RULE12
	end
end

wire line_lead = rising(line_sync, line_q_ff);
wire line_trail = rising(line_q_ff, line_sync);

////////////////////////////////////////////////////////////////////////
// clamp and holdover gating

reg [7:0] line_cnt_ff;
wire [8:0] clamp_end = {1'b0, clamp_start_ff} + {1'b0, clamp_len_ff};
wire int_clamp = line_cnt_ff >= clamp_start_ff &&
	{1'b0, line_cnt_ff} < clamp_end;
// internal holdover follows the processed, delayed frame sync
wire int_hold = frame_sync_out_o; // RULE5

always @(posedge clk_i) begin
	if (rst_i) begin
		line_cnt_ff <= 8'hff;
		clamp_o <= 1'b0;
		holdover_o <= 1'b0;
	end else begin
		// window counts from the trailing sync edge, saturates at max
		if (line_trail) begin
			line_cnt_ff <= 8'h00;
		end else if (line_cnt_ff != 8'hff) begin
			line_cnt_ff <= line_cnt_ff + 8'h01;
		end
		// gate pin is trusted to be high only in the black interval
		clamp_o <= ext_gate_en ? black_gate_in_i : int_clamp; // RULE2 RULE3 RULE13
		holdover_o <= ext_hold_en ? holdover_in_i : int_hold; // RULE4 RULE13
	end
end

////////////////////////////////////////////////////////////////////////
// sampling clock generation

reg [7:0] div_cnt_ff;
reg int_clk_ff;
reg [`PHASE_TAPS-1:0] phase_sr_ff;
reg sample_q_ff;
wire [7:0] half_m1 = (half_period_ff == 8'h00) ? 8'h00 :
	half_period_ff - 8'h01;
wire src_clk = ext_clk_en ? external_sample_clock_in_i : int_clk_ff; // RULE6
// taps sit after the source mux so either source can be shifted
wire phased_clk = phase_sr_ff[phase_ff]; // RULE7
// alternate-frame inversion is the host's job on the invert pin
wire nxt_sample_clock = phased_clk ^ sample_clock_invert_in_i; // RULE8 RULE9

always @(posedge clk_i) begin
	if (rst_i) begin
		div_cnt_ff <= 8'h00;
		int_clk_ff <= 1'b0;
		phase_sr_ff <= {`PHASE_TAPS{1'b0}};
		sample_clock_o <= 1'b0;
		sample_q_ff <= 1'b0;
		sample_strobe_o <= 1'b0;
	end else begin
		// leading line edges realign the divider unless holdover runs it free
		if (line_lead && !holdover_o) begin // RULE4
			div_cnt_ff <= 8'h00;
			int_clk_ff <= 1'b1;
		end else if (div_cnt_ff >= half_m1) begin
			div_cnt_ff <= 8'h00;
			int_clk_ff <= ~int_clk_ff;
		end else begin
			div_cnt_ff <= div_cnt_ff + 8'h01;
		end
		phase_sr_ff <= {phase_sr_ff[`PHASE_TAPS-2:0], src_clk};
		sample_clock_o <= nxt_sample_clock;
		sample_q_ff <= sample_clock_o;
		sample_strobe_o <= rising(sample_clock_o, sample_q_ff);
	end
end

endmodule // sync_clock_input_control
`default_nettype wire

// *** core/sync_clock_map.vh ***
// register offsets, field positions, reset values and sizes
// for the sync and sampling clock control block
`ifndef SYNC_CLOCK_MAP_VH
`define SYNC_CLOCK_MAP_VH

// serial device address, upper six bits fixed, lsb from strap
`define SER_ADDR_BASE 6'h26

// register offsets
`define REG_REVISION 8'h00
`define REG_INPUT_CTRL 8'h05
`define REG_SYNC_MODE 8'h0f
`define REG_CLAMP_START 8'h10
`define REG_CLAMP_LEN 8'h11
`define REG_PHASE 8'h12
`define REG_HALF_PERIOD 8'h13
`define REG_FRAME_DELAY 8'h14
`define REG_CLOCK_SRC 8'h15
`define REG_STATUS 8'h16

// field positions
`define INPUT_CTRL_SEL_B 0
`define INPUT_CTRL_GREEN 1
`define SYNC_MODE_EXT_GATE 7
`define SYNC_MODE_EXT_HOLD 5
`define CLOCK_SRC_EXT 0

// reset values
`define RST_INPUT_CTRL 8'h00
`define RST_SYNC_MODE 8'h00
`define RST_CLAMP_START 8'h04
`define RST_CLAMP_LEN 8'h08
`define RST_PHASE 5'h00
`define RST_HALF_PERIOD 8'h02
`define RST_FRAME_DELAY 4'h3
`define RST_CLOCK_SRC 8'h00

// sizes
`define PHASE_TAPS 32
`define FRAME_DELAY_TAPS 16

`endif

// *** testbench/serial_host.sv ***
// two-wire host model: drives scl, pulls sda low through drv
// assumes the bench resolves sda with a pull-up
`timescale 1ns/1ns
`default_nettype none
module serial_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_drv_o,
	output logic [7:0] rd_byte_o,
	output logic rd_done_o
);
	logic r;
	initial begin
		scl_o = 1'b1;
		sda_drv_o = 1'b1;
		rd_byte_o = 8'h00;
		rd_done_o = 1'b0;
	end
	// five cycles a phase, above the four the slave needs
	task automatic hold();
		repeat (5) @(negedge clk_i);
	endtask
	task automatic start();
		hold();
		sda_drv_o = 1'b1;
		hold();
		scl_o = 1'b1;
		hold();
		sda_drv_o = 1'b0;
		hold();
		scl_o = 1'b0;
	endtask
	task automatic stop();
		hold();
		sda_drv_o = 1'b0;
		hold();
		scl_o = 1'b1;
		hold();
		sda_drv_o = 1'b1;
		hold();
	endtask
	task automatic bit1(input logic b);
		hold();
		sda_drv_o = b;
		hold();
		scl_o = 1'b1;
		hold();
		r = sda_i;
		scl_o = 1'b0;
	endtask
	// reads end with a nack, so only single-byte reads
	task automatic xfer(input logic [7:0] d, input logic rd);
		logic [7:0] v;
		for (int i = 7; i >= 0; i--) begin
			bit1(rd | d[i]);
			v[i] = r;
		end
		bit1(1'b1);
		rd_byte_o = rd ? v : {7'h00, ~r};
		rd_done_o = 1'b1;
		@(negedge clk_i);
		rd_done_o = 1'b0;
	endtask
endmodule // serial_host
`default_nettype wire

// *** testbench/sync_ctl_chk_sva.sv ***
// assertions on the sync and clock control top ports
// assumes one clock domain with synchronous active high reset
`timescale 1ns/1ns
`default_nettype none
module sync_ctl_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic frame_sync_in_a_i,
	input wire logic frame_sync_in_b_i,
	input wire logic holdover_in_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic sample_clock_o,
	input wire logic sample_strobe_o,
	input wire logic clamp_o,
	input wire logic holdover_o,
	input wire logic frame_sync_out_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
// frame delay register stays at its reset tap 3, plus two stages
localparam int FS_LAG = 5;
////////////////////////////////////////////////////////////////
a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o &&
	!clamp_o && !holdover_o && !frame_sync_out_o && !sample_clock_o)
	else $error("output active after reset");
a_strobe_follows: assert property ($rose(sample_clock_o) |=> sample_strobe_o)
	else $error("no strobe after sample clock rise");
a_strobe_cause: assert property (sample_strobe_o |-> $past(sample_clock_o) &&
	!$past(sample_clock_o, 2)) else $error("strobe without clock rise");
a_ack_timing: assert property ($changed(sda_oe_o) && !$past(rst_i) |->
	!$past(scl_i) && $past(scl_i, 2)) else $error("sda drive off scl fall");
a_sda_low: assert property (sda_o == 1'b0)
	else $error("sda driven high");
a_hold_source: assert property (holdover_o == $past(holdover_in_i) ||
	holdover_o == $past(frame_sync_out_o)) else $error("holdover source wrong");
a_frame_rise: assert property ($rose(frame_sync_out_o) |->
	$past(frame_sync_in_a_i, FS_LAG) || $past(frame_sync_in_b_i, FS_LAG))
	else $error("frame sync out rose without input");
a_frame_fall: assert property ($fell(frame_sync_out_o) |->
	!$past(frame_sync_in_a_i, FS_LAG) || !$past(frame_sync_in_b_i, FS_LAG))
	else $error("frame sync out fell without input");
c_ack: cover property ($rose(sda_oe_o));
c_clamp: cover property ($rose(clamp_o));
c_hold: cover property ($rose(holdover_o));
endmodule // sync_ctl_chk
bind sync_clock_input_control sync_ctl_chk u_chk (.clk_i, .rst_i, .scl_i,
	.frame_sync_in_a_i, .frame_sync_in_b_i, .holdover_in_i, .sda_o,
	.sda_oe_o, .sample_clock_o, .sample_strobe_o, .clamp_o, .holdover_o,
	.frame_sync_out_o);
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for sync_clock_input_control
// assumes serial_host and the bound checker compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [7:0] rev = 8'h5a; // arbitrary revision value
	logic clk_i = 1'b0, rst_i = 1'b1, fa = 1'b0, fb = 1'b0, gate = 1'b0;
	logic hold_in = 1'b0, ext = 1'b0, inv = 1'b0, look = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [31:0] seed = 32'h36;
	logic [7:0] q[$];
	logic [7:0] note, d;
	logic [7:0] cs = 8'h00;
	logic [8:0] span = 9'h000;
	logic ln = 1'b0, grn = 1'b0;
	int n_errors = 0, n_compared = 0;
	wire scl, drv, sda_oe, done, sclk, clamp, hold_o, fso;
	wire [7:0] rbyte;
	wire sda = drv & ~sda_oe;
	wire [3:0] pins = {fso, hold_o, clamp, sclk};
	initial forever #10 clk_i = ~clk_i;
	sync_clock_input_control #(.REVISION(rev)) dut (.clk_i, .rst_i,
		.line_sync_in_a_i(ln), .frame_sync_in_a_i(fa),
		.line_sync_in_b_i(1'b0), .frame_sync_in_b_i(fb),
		.green_embedded_sync_in_a_i(grn),
		.green_embedded_sync_in_b_i(1'b0), .black_gate_in_i(gate),
		.holdover_in_i(hold_in), .external_sample_clock_in_i(ext),
		.sample_clock_invert_in_i(inv), .bus_address_strap_i(1'b1),
		.scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
		.sample_clock_o(sclk), .sample_strobe_o(), .clamp_o(clamp),
		.holdover_o(hold_o), .frame_sync_out_o(fso));
	serial_host host (.clk_i, .sda_i(sda), .scl_o(scl), .sda_drv_o(drv),
		.rd_byte_o(rbyte), .rd_done_o(done));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_pin(input logic e, input logic g);
		cmp_byte({7'h00, e}, {7'h00, g});
	endtask
	always @(posedge clk_i) begin
		if (done || look) begin
			note = q.size() > 0 ? q.pop_front() : 8'hee;
			if (done)
				cmp_byte(note, rbyte);
			else
				cmp_pin(note[0], pins[sel]);
			look <= 1'b0;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic see(input logic [1:0] k, input logic e);
		q.push_back({7'h00, e});
		sel = k;
		look = 1'b1;
		tick(1);
	endtask
	// line or green sync pulse; clamp is read one clock into the line
	task automatic pulse(input logic g);
		if (g)
			grn = 1'b1;
		else
			ln = 1'b1;
		tick(2);
		ln = 1'b0;
		grn = 1'b0;
		tick(3);
	endtask
	task automatic xb(input logic [7:0] b, input logic [7:0] e);
		q.push_back(e);
		host.xfer(b, 1'b0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host.start();
		xb(8'h9a, 8'h01);
		xb(a, 8'h01);
		xb(v, 8'h01);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host.start();
		xb(8'h9a, 8'h01);
		xb(a, 8'h01);
		host.start();
		xb(8'h9b, 8'h01);
		q.push_back(e);
		host.xfer(8'hff, 1'b1);
		host.stop();
	endtask
	task automatic results();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		tick(16);
		rst_i = 1'b0;
		tick(3);
		rd(8'h00, rev);
		host.start();
		xb(8'h98, 8'h00);
		host.stop();
		for (logic [7:0] a = 8'h10; a < 8'h12; a++) begin
			d = xs();
			if (a == 8'h10)
				cs = d;
			span = span + {1'b0, d};
			wr(a, d);
			rd(a, d);
		end
		$display("test register access done");
		wr(8'h0f, 8'ha0);
		// no line runs here, so the whole stretch counts as blanking
		gate = 1'b1;
		hold_in = 1'b1;
		tick(1);
		see(2'h1, 1'b1);
		see(2'h2, 1'b1);
		wr(8'h0f, 8'h00);
		// line counter sits saturated; a wide window covers its top
		see(2'h1, span > 9'h0ff);
		see(2'h2, 1'b0);
		gate = 1'b0;
		$display("test external gate and holdover done");
		pulse(1'b0);
		see(2'h1, cs <= 8'h01 && span > 9'h001);
		wr(8'h05, 8'h02);
		pulse(1'b0);
		see(2'h1, span > 9'h0ff);
		pulse(1'b1);
		see(2'h1, cs <= 8'h01 && span > 9'h001);
		$display("test line sync input done");
		fa = 1'b1;
		tick(4);
		see(2'h3, 1'b0);
		see(2'h3, 1'b1);
		see(2'h2, 1'b1);
		fa = 1'b0;
		wr(8'h05, 8'h01);
		fb = 1'b1;
		tick(5);
		see(2'h3, 1'b1);
		$display("test frame sync path done");
		wr(8'h15, 8'h01);
		rd(8'h16, {4'h0, 1'b1, span > 9'h0ff, 2'h3});
		see(2'h0, 1'b0);
		// a new frame begins with the sampling phase flipped
		fb = 1'b0;
		inv = 1'b1;
		tick(1);
		see(2'h0, 1'b1);
		inv = 1'b0;
		wr(8'h12, 8'h05);
		ext = 1'b1;
		tick(6);
		see(2'h0, 1'b0);
		see(2'h0, 1'b1);
		$display("test sampling clock done");
		for (int i = 0; i < 20 && q.size() > 0; i++)
			tick(1);
		if (q.size() > 0)
			n_errors++;
		results();
	end
endmodule // testbench
`default_nettype wire
